// [hw/jt_pkg.sv]
// jt_pkg: shared types and constants of the test access port
package jt_pkg;
    localparam int IR_W = 4;
    localparam int ID_W = 32;
    localparam int BSR_LEN = 8;

    // test access port controller states
    typedef enum logic [3:0] {
        ST_TLR = 4'hF,
        ST_RTI = 4'hC,
        ST_SEL_DR = 4'h7,
        ST_CAP_DR = 4'h6,
        ST_SHIFT_DR = 4'h2,
        ST_EX1_DR = 4'h1,
        ST_PAUSE_DR = 4'h3,
        ST_EX2_DR = 4'h0,
        ST_UPD_DR = 4'h5,
        ST_SEL_IR = 4'h4,
        ST_CAP_IR = 4'hE,
        ST_SHIFT_IR = 4'hA,
        ST_EX1_IR = 4'h9,
        ST_PAUSE_IR = 4'hB,
        ST_EX2_IR = 4'h8,
        ST_UPD_IR = 4'hD
    } jt_state_t;

    // instruction codes
    localparam logic [IR_W-1:0] IR_EXTEST = 4'h0;
    localparam logic [IR_W-1:0] IR_INTEST = 4'h1;
    localparam logic [IR_W-1:0] IR_SAMPLE = 4'h2;
    localparam logic [IR_W-1:0] IR_ABORT = 4'h8;
    localparam logic [IR_W-1:0] IR_DEBUG_PORT_ACCESS = 4'hA;
    localparam logic [IR_W-1:0] IR_ACCESS_PORT_ACCESS = 4'hB;
    localparam logic [IR_W-1:0] IR_IDCODE = 4'hE;
    localparam logic [IR_W-1:0] IR_BYPASS = 4'hF;

    // capture and reset values
    localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
    localparam logic [IR_W-1:0] IR_RESET = IR_IDCODE;
    localparam logic BYPASS_CAPTURE = 1'h0;

    // data chain selected by an instruction
    typedef enum logic [2:0] {
        CH_BYPASS = 3'h0,
        CH_IDCODE = 3'h1,
        CH_BSR = 3'h3,
        CH_CORE = 3'h2,
        CH_NONE = 3'h6
    } jt_chain_t;

    // instruction to chain decode
    function automatic jt_chain_t jt_decode(input logic [IR_W-1:0] ir);
        jt_chain_t ch;
        ch = CH_BYPASS;
        case (ir)
            IR_IDCODE: ch = CH_IDCODE;
            IR_SAMPLE: ch = CH_BSR;
            IR_EXTEST, IR_INTEST: ch = CH_NONE;
            IR_ABORT, IR_DEBUG_PORT_ACCESS, IR_ACCESS_PORT_ACCESS: ch = CH_CORE;
            default: ch = CH_BYPASS;
        endcase
        return ch;
    endfunction : jt_decode
endpackage : jt_pkg

// [hw/jt_fsm.sv]
// jt_fsm: test access port controller state machine
module jt_fsm (
    // link clock and reset
    input wire logic tck_i,
    input wire logic tap_rst_n_i,
    // mode select
    input wire logic tms_i,
    // current state
    output jt_pkg::jt_state_t state_o
);
    import jt_pkg::*;

    typedef struct packed {
        jt_state_t state;
    } jt_fsm_reg_t;

    jt_fsm_reg_t r;
    jt_fsm_reg_t next_r;

    always_comb begin
        next_r = r;
        unique case (r.state)
            ST_TLR: next_r.state = tms_i ? ST_TLR : ST_RTI;
            ST_RTI: next_r.state = tms_i ? ST_SEL_DR : ST_RTI;
            ST_SEL_DR: next_r.state = tms_i ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: next_r.state = tms_i ? ST_EX1_DR : ST_SHIFT_DR;
            ST_SHIFT_DR: next_r.state = tms_i ? ST_EX1_DR : ST_SHIFT_DR;
            ST_EX1_DR: next_r.state = tms_i ? ST_UPD_DR : ST_PAUSE_DR;
            ST_PAUSE_DR: next_r.state = tms_i ? ST_EX2_DR : ST_PAUSE_DR;
            ST_EX2_DR: next_r.state = tms_i ? ST_UPD_DR : ST_SHIFT_DR;
            ST_UPD_DR: next_r.state = tms_i ? ST_SEL_DR : ST_RTI;
            ST_SEL_IR: next_r.state = tms_i ? ST_TLR : ST_CAP_IR;
            ST_CAP_IR: next_r.state = tms_i ? ST_EX1_IR : ST_SHIFT_IR;
            ST_SHIFT_IR: next_r.state = tms_i ? ST_EX1_IR : ST_SHIFT_IR;
            ST_EX1_IR: next_r.state = tms_i ? ST_UPD_IR : ST_PAUSE_IR;
            ST_PAUSE_IR: next_r.state = tms_i ? ST_EX2_IR : ST_PAUSE_IR;
            ST_EX2_IR: next_r.state = tms_i ? ST_UPD_IR : ST_SHIFT_IR;
            ST_UPD_IR: next_r.state = tms_i ? ST_SEL_DR : ST_RTI;
        endcase
    end

    // state moves only on a rising link clock edge
    always_ff @(posedge tck_i or negedge tap_rst_n_i) begin
        if (!tap_rst_n_i) begin
            r.state <= ST_TLR;
        end else begin
            r <= next_r;
        end
    end

    assign state_o = r.state;

    a_five_ones_reset: assert property (
        @(posedge tck_i) disable iff (!tap_rst_n_i)
        tms_i [*5] |=> r.state == ST_TLR)
        else $error("five tms ones did not reach reset state");

    a_idle_stays: assert property (
        @(posedge tck_i) disable iff (!tap_rst_n_i)
        (r.state == ST_RTI && !tms_i) |=> r.state == ST_RTI)
        else $error("idle state left with tms low");

    a_shift_dr_path: assert property (
        @(posedge tck_i) disable iff (!tap_rst_n_i)
        (r.state == ST_SEL_DR && !tms_i) ##1 !tms_i |=> r.state == ST_SHIFT_DR)
        else $error("select to shift data path broken");

    c_reach_shift_ir: cover property (
        @(posedge tck_i) disable iff (!tap_rst_n_i)
        r.state == ST_SHIFT_IR);
endmodule : jt_fsm

// [hw/jt_tap.sv]
// jt_tap: test access port with instruction decode, data chains and output mux
// Behaviour
// - state graph follows the standard boundary-scan
// - instruction chain and holding register four bits
// - decode standard and core debug instructions
// - core instructions steer output to core, except while shifting the instruction
// - unknown instruction codes act as bypass
// - held instruction selects the data chain
// - extest and intest freeze every data chain
// - state decides capture, shift, update, chain
// - low test reset holds reset state asynchronously
// - power-on reset also gives reset state
// - reset state loads identify instruction
// - mode select sampled each rising edge
// - five mode-select ones reach reset state
// - data input sampled into selected chain
// - data output changes on falling edge only, except core data, which passes straight through
// - data output driven only while shifting
// - stopped clock keeps state and registers
module jt_tap #(
    parameter int BSR_N = jt_pkg::BSR_LEN,
    parameter logic [31:0] ID_CODE = 32'h0000_0001
) (
    // system clock domain
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic clk_en_i,
    // link pins
    input wire logic tck_i,
    input wire logic trst_n_i,
    input wire logic tms_i,
    input wire logic tdi_i,
    output logic tdo_o,
    output logic tdo_oe_o,
    // core debug controller, link clock domain
    input wire logic core_tdo_i,
    output logic core_sel_o,
    // device pins seen by the boundary chain
    input wire logic [BSR_N-1:0] pin_in_i,
    // boundary values toward pins, system clock domain
    output logic [BSR_N-1:0] bs_pin_o,
    output logic bs_drive_o,
    output logic bs_isolate_o
);
    import jt_pkg::*;

    // link clock domain state
    typedef struct packed {
        logic [IR_W-1:0] ir_sh;
        logic [IR_W-1:0] ir;
        logic byp;
        logic [ID_W-1:0] id_sh;
        logic [BSR_N-1:0] bsr_sh;
        logic [BSR_N-1:0] bsr_upd;
        logic upd_tgl;
        logic [BSR_N-1:0] pin_s1;
        logic [BSR_N-1:0] pin_s2;
    } jt_tck_reg_t;

    // falling edge output state
    typedef struct packed {
        logic tdo;
        logic oe;
        logic core;
    } jt_neg_reg_t;

    // system clock domain state
    typedef struct packed {
        logic tgl_s1;
        logic tgl_s2;
        logic tgl_s3;
        logic ext_s1;
        logic ext_s2;
        logic int_s1;
        logic int_s2;
        logic [BSR_N-1:0] bs_out;
    } jt_sys_reg_t;

    jt_tck_reg_t r;
    jt_tck_reg_t next_r;
    jt_neg_reg_t rn;
    jt_neg_reg_t next_rn;
    jt_sys_reg_t rs;
    jt_sys_reg_t next_rs;
    jt_state_t state;
    jt_chain_t chain;
    logic tap_rst_n;
    logic ser_out;
    logic in_extest;
    logic in_intest;

    assign tap_rst_n = trst_n_i & reset_n_i;

    jt_fsm u_fsm (
        .tck_i(tck_i),
        .tap_rst_n_i(tap_rst_n),
        .tms_i(tms_i),
        .state_o(state)
    );

    assign chain = jt_decode(r.ir);
    assign in_extest = (r.ir == IR_EXTEST);
    assign in_intest = (r.ir == IR_INTEST);
    assign core_sel_o = (chain == CH_CORE);

    // capture, shift and update per state and chain
    always_comb begin
        next_r = r;
        next_r.pin_s1 = pin_in_i;
        next_r.pin_s2 = r.pin_s1;
        if (state == ST_TLR) begin
            next_r.ir = IR_RESET;
        end
        if (state == ST_CAP_IR) begin
            next_r.ir_sh = IR_CAPTURE;
        end
        if (state == ST_SHIFT_IR) begin
            next_r.ir_sh = {tdi_i, r.ir_sh[IR_W-1:1]};
        end
        if (state == ST_UPD_IR) begin
            next_r.ir = r.ir_sh;
        end
        if (state == ST_CAP_DR) begin
            case (chain)
                CH_BYPASS: next_r.byp = BYPASS_CAPTURE;
                CH_IDCODE: next_r.id_sh = ID_CODE;
                CH_BSR: next_r.bsr_sh = r.pin_s2;
                default: next_r.byp = r.byp;
            endcase
        end
        if (state == ST_SHIFT_DR) begin
            case (chain)
                CH_BYPASS: next_r.byp = tdi_i;
                CH_IDCODE: next_r.id_sh = {tdi_i, r.id_sh[ID_W-1:1]};
                CH_BSR: next_r.bsr_sh = {tdi_i, r.bsr_sh[BSR_N-1:1]};
                default: next_r.byp = r.byp;
            endcase
        end
        if (state == ST_UPD_DR && chain == CH_BSR) begin
            next_r.bsr_upd = r.bsr_sh;
            next_r.upd_tgl = ~r.upd_tgl;
        end
    end

    // serial bit of the accessed chain
    always_comb begin
        ser_out = r.byp;
        if (state == ST_SHIFT_IR) begin
            ser_out = r.ir_sh[0];
        end else if (chain == CH_IDCODE) begin
            ser_out = r.id_sh[0];
        end else if (chain == CH_BSR) begin
            ser_out = r.bsr_sh[0];
        end
    end

    always_comb begin
        next_rn.tdo = ser_out;
        next_rn.oe = (state == ST_SHIFT_IR) || (state == ST_SHIFT_DR && chain != CH_NONE);
        next_rn.core = (chain == CH_CORE) && (state != ST_SHIFT_IR);
    end

    // registers move only on link clock edges
    always_ff @(posedge tck_i or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            r <= '0;
            r.ir <= IR_RESET;
        end else begin
            r <= next_r;
        end
    end

    // output timing on the falling edge
    always_ff @(negedge tck_i or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            rn <= '0;
        end else begin
            rn <= next_rn;
        end
    end

    assign tdo_o = rn.core ? core_tdo_i : rn.tdo;
    assign tdo_oe_o = rn.oe;

    // system side: toggle handshake for update, level sync for modes
    always_comb begin
        next_rs = rs;
        next_rs.tgl_s1 = r.upd_tgl;
        next_rs.tgl_s2 = rs.tgl_s1;
        next_rs.tgl_s3 = rs.tgl_s2;
        next_rs.ext_s1 = in_extest;
        next_rs.ext_s2 = rs.ext_s1;
        next_rs.int_s1 = in_intest;
        next_rs.int_s2 = rs.int_s1;
        if (rs.tgl_s2 != rs.tgl_s3) begin
            next_rs.bs_out = r.bsr_upd;
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rs <= '0;
        end else if (clk_en_i) begin
            rs <= next_rs;
        end
    end

    // held boundary values act on pins under extest
    assign bs_pin_o = rs.bs_out;
    assign bs_drive_o = rs.ext_s2;
    assign bs_isolate_o = rs.int_s2;

    a_ir_reset_load: assert property (
        @(posedge tck_i) disable iff (!tap_rst_n)
        state == ST_TLR |=> r.ir == IR_IDCODE)
        else $error("reset state did not load identify instruction");

    a_ir_capture_bits: assert property (
        @(posedge tck_i) disable iff (!tap_rst_n)
        state == ST_CAP_IR |=> r.ir_sh[1:0] == 2'h1)
        else $error("instruction capture pattern wrong");

    a_ir_update_take: assert property (
        @(posedge tck_i) disable iff (!tap_rst_n)
        state == ST_UPD_IR |=> r.ir == $past(r.ir_sh))
        else $error("instruction not taken on update");

    a_bypass_one_delay: assert property (
        @(posedge tck_i) disable iff (!tap_rst_n)
        (state == ST_SHIFT_DR && chain == CH_BYPASS) |=> r.byp == $past(tdi_i))
        else $error("bypass bit not one cycle of tdi");

    a_test_freeze: assert property (
        @(posedge tck_i) disable iff (!tap_rst_n)
        (in_extest || in_intest) && state != ST_UPD_IR |=>
            $stable(r.bsr_sh) && $stable(r.bsr_upd) && $stable(r.byp) && $stable(r.id_sh))
        else $error("chain changed under extest or intest");

    a_tdo_quiet: assert property (
        @(negedge tck_i) disable iff (!tap_rst_n)
        (state != ST_SHIFT_IR && state != ST_SHIFT_DR) |=> !rn.oe)
        else $error("tdo driven outside shift");

    a_unknown_bypass: assert property (
        @(posedge tck_i) disable iff (!tap_rst_n)
        (r.ir == 4'h5) |-> chain == CH_BYPASS)
        else $error("unimplemented code not decoded as bypass");

    a_core_mux: assert property (
        @(posedge tck_i) disable iff (!tap_rst_n)
        (r.ir == IR_DEBUG_PORT_ACCESS && state == ST_SHIFT_DR) |-> core_sel_o && tdo_o == core_tdo_i)
        else $error("core instruction did not select core output");

    a_ir_hold: assert property (
        @(posedge tck_i) disable iff (!tap_rst_n)
        (state != ST_UPD_IR && state != ST_TLR) |=> $stable(r.ir))
        else $error("held instruction changed outside update");

    a_ir_shift_in: assert property (
        @(posedge tck_i) disable iff (!tap_rst_n)
        state == ST_SHIFT_IR |=> r.ir_sh == {$past(tdi_i), $past(r.ir_sh[IR_W-1:1])})
        else $error("instruction chain did not shift tdi in");

    a_id_capture: assert property (
        @(posedge tck_i) disable iff (!tap_rst_n)
        (state == ST_CAP_DR && chain == CH_IDCODE) |=> r.id_sh == ID_CODE)
        else $error("identity chain not captured");

    a_bypass_capture: assert property (
        @(posedge tck_i) disable iff (!tap_rst_n)
        (state == ST_CAP_DR && chain == CH_BYPASS) |=> r.byp == BYPASS_CAPTURE)
        else $error("bypass bit did not capture zero");

    a_bsr_capture: assert property (
        @(posedge tck_i) disable iff (!tap_rst_n)
        (state == ST_CAP_DR && chain == CH_BSR) |=> r.bsr_sh == $past(r.pin_s2))
        else $error("boundary chain did not capture pins");

    a_id_shift: assert property (
        @(posedge tck_i) disable iff (!tap_rst_n)
        (state == ST_SHIFT_DR && chain == CH_IDCODE) |=> r.id_sh == {$past(tdi_i), $past(r.id_sh[ID_W-1:1])})
        else $error("identity chain did not shift");

    a_bsr_shift: assert property (
        @(posedge tck_i) disable iff (!tap_rst_n)
        (state == ST_SHIFT_DR && chain == CH_BSR) |=> r.bsr_sh == {$past(tdi_i), $past(r.bsr_sh[BSR_N-1:1])})
        else $error("boundary chain did not shift");

    a_bsr_update: assert property (
        @(posedge tck_i) disable iff (!tap_rst_n)
        (state == ST_UPD_DR && chain == CH_BSR) |=> r.bsr_upd == $past(r.bsr_sh) && r.upd_tgl != $past(r.upd_tgl))
        else $error("boundary word not updated");

    a_upd_hold: assert property (
        @(posedge tck_i) disable iff (!tap_rst_n)
        !(state == ST_UPD_DR && chain == CH_BSR) |=> $stable(r.bsr_upd) && $stable(r.upd_tgl))
        else $error("boundary word changed outside update");

    a_oe_shift_ir: assert property (
        @(negedge tck_i) disable iff (!tap_rst_n)
        state == ST_SHIFT_IR |=> rn.oe)
        else $error("tdo not driven while shifting instruction");

    a_oe_extest_off: assert property (
        @(negedge tck_i) disable iff (!tap_rst_n)
        (state == ST_SHIFT_DR && chain == CH_NONE) |=> !rn.oe)
        else $error("tdo driven under extest or intest");

    a_tdo_ir_bit: assert property (
        @(negedge tck_i) disable iff (!tap_rst_n)
        state == ST_SHIFT_IR |=> tdo_o == $past(r.ir_sh[0]))
        else $error("tdo not from own instruction chain");

    a_core_shift_dr: assert property (
        @(posedge tck_i) disable iff (!tap_rst_n)
        (state == ST_SHIFT_DR && chain == CH_CORE) |-> tdo_oe_o && tdo_o == core_tdo_i)
        else $error("core data shift not routed to tdo");

    a_core_sel_level: assert property (
        @(posedge tck_i) disable iff (!tap_rst_n)
        core_sel_o == (r.ir == IR_ABORT || r.ir == IR_DEBUG_PORT_ACCESS || r.ir == IR_ACCESS_PORT_ACCESS))
        else $error("core select does not match instruction");

    a_bypass_out: assert property (
        @(negedge tck_i) disable iff (!tap_rst_n)
        (state == ST_SHIFT_DR && chain == CH_BYPASS) |=> rn.tdo == $past(r.byp))
        else $error("bypass bit not presented on tdo");

    a_unknown_oe: assert property (
        @(negedge tck_i) disable iff (!tap_rst_n)
        (state == ST_SHIFT_DR && r.ir == 4'h5) |=> rn.oe)
        else $error("unimplemented code left no serial path");

    a_sys_load: assert property (
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        (clk_en_i && rs.tgl_s2 != rs.tgl_s3) |=> bs_pin_o == $past(r.bsr_upd))
        else $error("boundary word not taken on system side");

    c_idcode_shift: cover property (
        @(posedge tck_i) disable iff (!tap_rst_n)
        state == ST_SHIFT_DR && chain == CH_IDCODE);

    c_extest_held: cover property (
        @(posedge tck_i) disable iff (!tap_rst_n)
        in_extest && state == ST_RTI);

    c_core_selected: cover property (
        @(posedge tck_i) disable iff (!tap_rst_n)
        core_sel_o && state == ST_SHIFT_DR);

    c_core_ir_update: cover property (
        @(posedge tck_i) disable iff (!tap_rst_n)
        state == ST_UPD_IR && chain == CH_CORE);
endmodule : jt_tap

// [verif/jt_tester.sv]
// jt_tester: behavioural probe driving the link pins
module jt_tester (
    // link pins
    output logic tck_o,
    output logic tms_o,
    output logic tdi_o,
    input wire logic tdo_i,
    input wire logic tdo_oe_i
);
    timeunit 1ns;
    timeprecision 100ps;
    logic bit_q;
    logic oe_seen;
    initial begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b0;
        oe_seen = 1'b0;
    end
    // one link period, clock rests low between frames
    task automatic tick(input logic tms, input logic tdi);
        tms_o = tms;
        tdi_o = tdi;
        #41;
        bit_q = tdo_i;
        oe_seen = oe_seen | tdo_oe_i;
        tck_o = 1'b1;
        #39;
        tck_o = 1'b0;
    endtask : tick
    // idle to shift, n bits lsb first, update, back to idle
    task automatic scan(input logic ir, input int n, input logic [63:0] din, output logic [63:0] dout);
        dout = '0;
        tick(1'b0, 1'b0);
        tick(1'b1, 1'b0);
        if (ir) tick(1'b1, 1'b0);
        tick(1'b0, 1'b0);
        tick(1'b0, 1'b0);
        for (int i = 0; i < n; i++) begin
            tick(i == n - 1, din[i]);
            dout[i] = bit_q;
        end
        tick(1'b1, 1'b0);
        tick(1'b0, 1'b0);
    endtask : scan
endmodule : jt_tester

// [verif/jtag_tap_controller_bench.sv]
// jtag_tap_controller_bench: self-checking bench of the test access port
module jtag_tap_controller_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import jt_pkg::*;
    localparam logic [31:0] ID_V = 32'h1234_5679; // arbitrary, bit 0 set
    logic sys_clk_i, reset_n_i, trst_n_i, core_tdo_i;
    logic tck, tms, tdi, tdo, tdo_oe, core_sel, bs_drive, bs_isolate, tdo_pin;
    logic [7:0] pin_in, bs_pin;
    logic [63:0] d;
    int mismatches = 0;
    int comparisons = 0;
    assign tdo_pin = tdo_oe ? tdo : 1'b1;
    jt_tap #(.BSR_N(8), .ID_CODE(ID_V)) dut_u (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
        .clk_en_i(1'b1), .tck_i(tck), .trst_n_i(trst_n_i), .tms_i(tms), .tdi_i(tdi), .tdo_o(tdo),
        .tdo_oe_o(tdo_oe), .core_tdo_i(core_tdo_i), .core_sel_o(core_sel), .pin_in_i(pin_in),
        .bs_pin_o(bs_pin), .bs_drive_o(bs_drive), .bs_isolate_o(bs_isolate));
    jt_tester tester_u (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo_pin), .tdo_oe_i(tdo_oe));
    initial begin
        sys_clk_i = 1'b0;
        forever #4 sys_clk_i = ~sys_clk_i;
    end
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : check
    task automatic end_sim;
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_sim
    always @(tdo) begin
        if (tck === 1'b1 && tdo_oe === 1'b1 && core_sel === 1'b0) check(1'b1, 1'b0);
    end
    task automatic load_ir(input logic [3:0] code);
        tester_u.scan(1'b1, 4, {60'h0, code}, d);
        check(d[3:0], IR_CAPTURE);
    endtask : load_ir
    task automatic t_idcode;
        check(tdo_oe, 1'b0);
        tester_u.scan(1'b0, 32, 64'h0, d);
        check(d[31:0], ID_V);
    endtask : t_idcode
    task automatic t_bypass;
        logic [3:0] codes [3];
        codes = '{IR_BYPASS, 4'h5, 4'hC};
        foreach (codes[k]) begin
            load_ir(codes[k]);
            check(core_sel, 1'b0);
            tester_u.scan(1'b0, 9, 64'h1A5, d);
            check(d[8:0], 9'h14A);
        end
    endtask : t_bypass
    task automatic t_core;
        logic [3:0] codes [3];
        codes = '{IR_ABORT, IR_DEBUG_PORT_ACCESS, IR_ACCESS_PORT_ACCESS};
        foreach (codes[k]) begin
            load_ir(codes[k]);
            check(core_sel, 1'b1);
            core_tdo_i = (k == 1);
            tester_u.scan(1'b0, 6, 64'h0, d);
            check(d[5:0], (k == 1) ? 6'h3F : 6'h00);
        end
        core_tdo_i = 1'b0;
    endtask : t_core
    task automatic t_sample;
        @(negedge sys_clk_i);
        pin_in = 8'hA5;
        load_ir(IR_SAMPLE);
        #400;
        tester_u.scan(1'b0, 8, 64'h3C, d);
        check(d[7:0], 8'hA5);
        repeat (8) @(posedge sys_clk_i);
        check(bs_pin, 8'h3C);
    endtask : t_sample
    task automatic t_freeze;
        load_ir(IR_EXTEST);
        repeat (4) @(posedge sys_clk_i);
        check({bs_drive, bs_isolate}, 2'b10);
        tester_u.oe_seen = 1'b0;
        tester_u.scan(1'b0, 8, 64'hFF, d);
        check(tester_u.oe_seen, 1'b0);
        repeat (8) @(posedge sys_clk_i);
        check(bs_pin, 8'h3C);
        load_ir(IR_INTEST);
        repeat (4) @(posedge sys_clk_i);
        check({bs_drive, bs_isolate}, 2'b01);
    endtask : t_freeze
    task automatic t_tms_reset;
        load_ir(IR_BYPASS);
        tester_u.tick(1'b1, 1'b0);
        tester_u.tick(1'b0, 1'b0);
        tester_u.tick(1'b0, 1'b0);
        repeat (5) tester_u.tick(1'b1, 1'b0);
        t_idcode();
    endtask : t_tms_reset
    task automatic t_trst;
        load_ir(IR_BYPASS);
        tester_u.tick(1'b0, 1'b0);
        tester_u.tick(1'b1, 1'b0);
        tester_u.tick(1'b1, 1'b0);
        tester_u.tick(1'b0, 1'b0);
        tester_u.tick(1'b0, 1'b0);
        trst_n_i = 1'b0;
        #20;
        check(tdo_oe, 1'b0);
        tester_u.tick(1'b0, 1'b0);
        tester_u.tick(1'b1, 1'b0);
        trst_n_i = 1'b1;
        t_idcode();
    endtask : t_trst
    initial begin
        reset_n_i = 1'b0;
        trst_n_i = 1'b0;
        core_tdo_i = 1'b0;
        pin_in = 8'h00;
        repeat (2) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
        reset_n_i = 1'b1;
        tester_u.tick(1'b1, 1'b0);
        trst_n_i = 1'b1;
        t_idcode();
        t_bypass();
        t_core();
        t_sample();
        t_freeze();
        t_tms_reset();
        t_trst();
        end_sim();
    end
    initial begin
        #200000;
        mismatches++;
        end_sim();
    end
endmodule : jtag_tap_controller_bench
